// ### testbench/fpu_exception_signaling_bench.sv
// Self-checking bench for the floating-point exception signalling unit.
// Assumes the far side model and a 100 MHz clock.
module fpu_exception_signaling_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset, psel, penable, pwrite, instrValid, opSize32, excValid;
    logic pready, pslverr, instrGo, instrFault, tagAbridged, unitReinit, err;
    logic fpuErrorOutputN, errorStatusN, irq, coprocErrorN, errCmd, nativeSel;
    logic irqLine;
    logic [7:0] paddr, faultVector;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] imageAddrLow;
    logic [5:0] restoreFlags, excFlags;
    logic [9:0] imageBytes;
    fpuexc_pkg::fpuexc_instr_type instrClass;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    fpuexc_top dut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .instrValid, .instrClass, .opSize32,
        .imageAddrLow, .restoreFlags, .excValid, .excFlags, .coprocErrorN,
        .instrGo, .instrFault, .faultVector, .imageBytes, .tagAbridged,
        .unitReinit, .fpuErrorOutputN, .errorStatusN, .irq);
    fpuexc_core_model model (.errCmd, .fpuErrorOutputN, .nativeSel,
        .coprocErrorN, .legacyErrorIrqLine(irqLine));
    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            errors++;
            test_done();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    // APB transfer, waits for pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Issue one instruction; answer lands one cycle later
    task automatic issue(input fpuexc_pkg::fpuexc_instr_type c, input logic [3:0] al);
        @(posedge clk);
        instrValid <= 1'b1;
        instrClass <= c;
        imageAddrLow <= al;
        @(posedge clk);
        instrValid <= 1'b0;
        #1;
    endtask
    task automatic report(input logic [5:0] f);
        @(posedge clk);
        excValid <= 1'b1;
        excFlags <= f;
        @(posedge clk);
        excValid <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_defer();
        apb(1'b0, fpuexc_pkg::OFF_MASKS, 32'h0);
        check(rd, 32'h0000003f, "mask reset");
        apb(1'b0, 8'h18, 32'h0);
        check(32'(err), 32'h1, "unmapped");
        apb(1'b1, fpuexc_pkg::OFF_MASKS, 32'h0);
        apb(1'b1, fpuexc_pkg::OFF_EVTMASK, 32'h0000000f);
        report(6'h01);
        check(32'({errorStatusN, fpuErrorOutputN}), 32'h0, "err lines");
        check(32'(irqLine), 32'h1, "routed");
        issue(fpuexc_pkg::IC_NOWAIT, 4'h0);
        check(32'({instrGo, instrFault}), 32'h2, "nowait");
        issue(fpuexc_pkg::IC_ARITH, 4'h0);
        check(32'({instrFault, faultVector}), 32'h110, "numeric");
        @(posedge clk);
        #1;
        check(32'(irq), 32'h1, "irq set");
        apb(1'b1, fpuexc_pkg::OFF_EVT, 32'h0000000f);
        @(posedge clk);
        #1;
        check(32'(irq), 32'h0, "irq clear");
        $display("test defer done");
    endtask
    task automatic test_prio();
        apb(1'b1, fpuexc_pkg::OFF_CTRL, 32'h00000008);
        issue(fpuexc_pkg::IC_ARITH, 4'h0);
        check(32'({instrFault, faultVector}), 32'h107, "not-avail first");
        issue(fpuexc_pkg::IC_WAIT, 4'h0);
        check(32'({instrFault, faultVector}), 32'h110, "wait");
        apb(1'b1, fpuexc_pkg::OFF_CTRL, 32'h0);
        $display("test prio done");
    endtask
    task automatic test_save();
        opSize32 <= 1'b0;
        issue(fpuexc_pkg::IC_LEGACY_SAVE_NOWAIT, 4'h0);
        check(32'({instrGo, unitReinit, tagAbridged, imageBytes}), 32'h185e, "fns");
        @(posedge clk);
        #1;
        check(32'(fpuErrorOutputN), 32'h1, "reinit");
        apb(1'b1, fpuexc_pkg::OFF_MASKS, 32'h0);
        restoreFlags <= 6'h01;
        opSize32 <= 1'b1;
        issue(fpuexc_pkg::IC_LEGACY_RESTORE, 4'h0);
        check(32'({instrGo, imageBytes}), 32'h46c, "restore");
        issue(fpuexc_pkg::IC_ARITH, 4'h0);
        check(32'({instrFault, faultVector}), 32'h110, "refault");
        $display("test save done");
    endtask
    task automatic test_ext();
        apb(1'b1, fpuexc_pkg::OFF_STATUS, 32'h0);
        issue(fpuexc_pkg::IC_EXTENDED_SAVE, 4'h0);
        check(32'({instrGo, unitReinit, tagAbridged, imageBytes}), 32'h1600, "fx");
        issue(fpuexc_pkg::IC_EXTENDED_RESTORE, 4'h8);
        check(32'({instrFault, faultVector}), 32'h10d, "align");
        apb(1'b0, fpuexc_pkg::OFF_INFO, 32'h0);
        check(rd, 32'h000d0200, "info");
        $display("test ext done");
    endtask
    task automatic test_native();
        apb(1'b1, fpuexc_pkg::OFF_CTRL, 32'h00000020);
        nativeSel <= 1'b1;
        report(6'h02);
        check(32'(fpuErrorOutputN), 32'h0, "out native");
        check(32'(irqLine), 32'h0, "route off");
        issue(fpuexc_pkg::IC_ARITH, 4'h0);
        check(32'({instrFault, faultVector}), 32'h110, "native");
        apb(1'b1, fpuexc_pkg::OFF_STATUS, 32'h0);
        errCmd <= 1'b1;
        repeat (3) @(posedge clk);
        issue(fpuexc_pkg::IC_ARITH, 4'h0);
        check(32'({instrGo, instrFault}), 32'h2, "pin ignored");
        apb(1'b1, fpuexc_pkg::OFF_CTRL, 32'h0);
        nativeSel <= 1'b0;
        issue(fpuexc_pkg::IC_ARITH, 4'h0);
        check(32'({instrFault, faultVector}), 32'h110, "pin");
        errCmd <= 1'b0;
        $display("test native done");
    endtask
    task automatic test_done();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Reset, then the scenarios in turn
    initial
    begin
        {reset, psel, penable, pwrite, instrValid, opSize32, excValid} = 7'h40;
        {errCmd, nativeSel, paddr, pwdata, imageAddrLow} = '0;
        {restoreFlags, excFlags} = '0;
        instrClass = fpuexc_pkg::IC_WAIT;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        test_defer();
        test_prio();
        test_save();
        test_ext();
        test_native();
        test_done();
    end
endmodule

// ### testbench/fpuexc_core_model.sv
// Far side model: external coprocessor error pin and interrupt router.
// Assumes the bench commands the pin and mirrors the native select bit.
module fpuexc_core_model
(
    input wire logic errCmd, // Bench asks for an external error
    input wire logic fpuErrorOutputN, // Unit error output
    input wire logic nativeSel, // Native reporting selected
    output logic coprocErrorN, // External error pin, low active
    output logic legacyErrorIrqLine // Routed error interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pin is low only while the bench commands an error
    assign coprocErrorN = !errCmd;
    assign legacyErrorIrqLine = !fpuErrorOutputN && !nativeSel;
endmodule

// ### verilog/fpuexc_fault_arb.sv
// Fault priority for an issuing floating-point instruction.
// Assumes all inputs are same-clock levels valid with the issue strobe.
module fpuexc_fault_arb
(
    input wire logic tsFlag, // Task switched flag
    input wire logic isFp, // Instruction is floating-point
    input wire logic misaligned, // Extended image misaligned
    input wire logic waits, // Instruction checks pending errors
    input wire logic pending, // Numeric error line active
    input wire logic [7:0] alignVector, // Vector for misalignment
    output logic fault, // Instruction must fault
    output logic [7:0] vector, // Vector of the fault taken
    output logic notAvailTaken, // Fault is device not available
    output logic numTaken, // Fault is numeric
    output logic alignTaken // Fault is misalignment
);
    assign notAvailTaken = tsFlag && isFp;
    assign alignTaken = !notAvailTaken && misaligned;
    assign numTaken = !notAvailTaken && !alignTaken && waits && pending;
    assign fault = notAvailTaken || alignTaken || numTaken;
    assign vector = notAvailTaken ? fpuexc_pkg::VEC_NOT_AVAIL
        : alignTaken ? alignVector
        : numTaken ? fpuexc_pkg::VEC_NUMERIC : 8'h00;
endmodule

// ### verilog/fpuexc_image_sizer.sv
// Image size, alignment and tag layout decode for state save/restore.
// Assumes the class and address come from same-clock core logic.
module fpuexc_image_sizer
(
    input wire fpuexc_pkg::fpuexc_instr_type instrClass, // Instruction class
    input wire logic opSize32, // 32-bit operand mode
    input wire logic [3:0] addrLow, // Low image address bits
    output logic [fpuexc_pkg::BYTES_W-1:0] imageBytes, // Image length
    output logic misaligned, // Extended image not aligned
    output logic tagAbridged // Extended tag word layout
);
    logic isLegacy;
    logic isExtended;

    // Class decode
    assign isLegacy = (instrClass == fpuexc_pkg::IC_LEGACY_SAVE_NOWAIT)
        || (instrClass == fpuexc_pkg::IC_LEGACY_SAVE_WAIT)
        || (instrClass == fpuexc_pkg::IC_LEGACY_RESTORE);
    assign isExtended = (instrClass == fpuexc_pkg::IC_EXTENDED_SAVE)
        || (instrClass == fpuexc_pkg::IC_EXTENDED_RESTORE);

    assign imageBytes = isExtended ? fpuexc_pkg::BYTES_EXTENDED
        : !isLegacy ? '0
        : opSize32 ? fpuexc_pkg::BYTES_LEGACY32 : fpuexc_pkg::BYTES_LEGACY16;
    assign misaligned = isExtended && ((addrLow & fpuexc_pkg::ALIGN_LOW_MASK) != 4'h0);
    assign tagAbridged = isExtended;
endmodule

// ### verilog/fpuexc_pkg.sv
// Shared constants for the floating-point exception signalling unit.
// Assumes a single 100 MHz core clock and an APB register port.
package fpuexc_pkg;
    localparam int unsigned FLAG_W = 6;
    localparam int unsigned EVT_W = 4;
    localparam int unsigned BYTES_W = 10;
    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASKS = 8'h08;
    localparam logic [7:0] OFF_EVT = 8'h0c;
    localparam logic [7:0] OFF_EVTMASK = 8'h10;
    localparam logic [7:0] OFF_INFO = 8'h14;
    ////////////////////////////////////////////////////////////////////////
    // Field positions and reset values
    localparam int unsigned TASK_SWITCHED_BIT = 3;
    localparam int unsigned NATIVE_SEL_BIT = 5;
    localparam int unsigned EVT_NOT_AVAIL = 0;
    localparam int unsigned EVT_NUM = 1;
    localparam int unsigned EVT_ALIGN = 2;
    localparam int unsigned EVT_EXC = 3;
    localparam int unsigned INFO_VEC_LSB = 16;
    localparam logic [FLAG_W-1:0] MASK_RESET = 6'h3f;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 6'h00;
    ////////////////////////////////////////////////////////////////////////
    // Fault vectors and image sizes
    localparam logic [7:0] VEC_NOT_AVAIL = 8'h07;
    localparam logic [7:0] VEC_NUMERIC = 8'h10;
    localparam logic [BYTES_W-1:0] BYTES_LEGACY16 = 10'h05e;
    localparam logic [BYTES_W-1:0] BYTES_LEGACY32 = 10'h06c;
    localparam logic [BYTES_W-1:0] BYTES_EXTENDED = 10'h200;
    localparam logic [3:0] ALIGN_LOW_MASK = 4'hf;
    ////////////////////////////////////////////////////////////////////////
    // Instruction classes seen by the unit
    typedef enum logic [2:0] {
        IC_WAIT,
        IC_ARITH,
        IC_NOWAIT,
        IC_LEGACY_SAVE_NOWAIT,
        IC_LEGACY_SAVE_WAIT,
        IC_LEGACY_RESTORE,
        IC_EXTENDED_SAVE,
        IC_EXTENDED_RESTORE
    } fpuexc_instr_type;

    // Classes that check for a pending numeric exception first
    function automatic logic fpuexc_waits(input fpuexc_instr_type ic);
        return (ic != IC_NOWAIT) && (ic != IC_LEGACY_SAVE_NOWAIT);
    endfunction

    // Classes that are floating-point instructions proper
    function automatic logic fpuexc_is_fp(input fpuexc_instr_type ic);
        return ic != IC_WAIT;
    endfunction
endpackage

// ### verilog/fpuexc_top.sv
// Exception signalling unit of a floating-point coprocessor.
// Assumes an APB master, core issue logic on clk, and an external
// coprocessor error pin that is asynchronous to clk.
// What this block does
// - Device-not-available fault is serviced before a pending numeric fault.
// - No-wait legacy save with pending unmasked error pulses the error output.
// - Restore reloads pending flags; next waiting instruction faults again.
// - Legacy save/restore image is 94 bytes (16-bit) or 108 bytes (32-bit).
// - Extended save/restore image is 512 bytes, both register sets.
// - Extended image must be 16-byte aligned; misalignment faults.
// - Extended image tag word and field layout differ from legacy image.
// - Legacy save reinitializes the unit; extended save leaves it unchanged.
// - Unmasked exception is recorded and the active-low status line asserted.
// - Error line checked before next waiting instruction; active gives vector 16.
// - No-wait instructions run without the fault; the error stays pending, except after a no-wait legacy save, which clears it.
// - Native select bit 5 keeps delivery inside the chip, pin ignored.
// - Native mode raises vector 16 right before the next waiting instruction.
// - Error output still asserts in native mode, one cycle after the unmasked exception is recorded.
// - Task-switched flag bit 3 makes any FP instruction fault with vector 7.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
module fpuexc_top
#(
    parameter logic [7:0] ALIGN_VECTOR = 8'h0d // Misalignment fault vector
)
(
    input wire logic clk, // Core clock, 100 MHz
    input wire logic reset, // Asynchronous reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic instrValid, // Instruction issue strobe
    input wire fpuexc_pkg::fpuexc_instr_type instrClass, // Issued class
    input wire logic opSize32, // 32-bit operand mode
    input wire logic [3:0] imageAddrLow, // Image address low bits
    input wire logic [5:0] restoreFlags, // Flags read from image
    input wire logic excValid, // Exception report strobe
    input wire logic [5:0] excFlags, // Reported exception flags
    input wire logic coprocErrorN, // External error pin, low active
    output logic instrGo, // Instruction may execute
    output logic instrFault, // Instruction faults
    output logic [7:0] faultVector, // Vector of the fault
    output logic [9:0] imageBytes, // Image length to move
    output logic tagAbridged, // Extended tag layout in use
    output logic unitReinit, // Unit state reinitialized
    output logic fpuErrorOutputN, // Error output, low active
    output logic errorStatusN, // Error status line, low active
    output logic irq // Level interrupt request
);
    localparam int unsigned FW = fpuexc_pkg::FLAG_W;
    localparam int unsigned EW = fpuexc_pkg::EVT_W;

    ////////////////////////////////////////////////////////////////////////
    // State
    logic taskSwitchedFlag_reg;
    logic nativeErrorReportSelect_reg;
    logic [FW-1:0] flags_reg;
    logic [FW-1:0] flags_next;
    logic [FW-1:0] masks_reg;
    logic [FW-1:0] masks_next;
    logic [EW-1:0] evt_reg;
    logic [EW-1:0] evtMask_reg;
    logic [1:0] pinSync_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic instrGo_reg;
    logic instrFault_reg;
    logic [7:0] faultVector_reg;
    logic [9:0] imageBytes_reg;
    logic tagAbridged_reg;
    logic unitReinit_reg;
    logic fpuErrorOutputN_reg;
    logic errorStatusN_reg;
    logic irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    logic apbAccess;
    logic wrEn;
    logic hitCtrl;
    logic hitStatus;
    logic hitMasks;
    logic hitEvt;
    logic hitEvtMask;
    logic hitInfo;
    logic hitAny;
    logic [31:0] readMux;

    // Access phase before ready; the write lands with ready high
    assign apbAccess = psel && penable && !pready_reg;
    assign wrEn = psel && penable && pwrite && pready_reg;
    assign hitCtrl = paddr == fpuexc_pkg::OFF_CTRL;
    assign hitStatus = paddr == fpuexc_pkg::OFF_STATUS;
    assign hitMasks = paddr == fpuexc_pkg::OFF_MASKS;
    assign hitEvt = paddr == fpuexc_pkg::OFF_EVT;
    assign hitEvtMask = paddr == fpuexc_pkg::OFF_EVTMASK;
    assign hitInfo = paddr == fpuexc_pkg::OFF_INFO;
    assign hitAny = hitCtrl || hitStatus || hitMasks || hitEvt || hitEvtMask || hitInfo;

    // Read data selection, unmapped reads give zero
    assign readMux = hitCtrl ? (32'(taskSwitchedFlag_reg) << fpuexc_pkg::TASK_SWITCHED_BIT)
            | (32'(nativeErrorReportSelect_reg) << fpuexc_pkg::NATIVE_SEL_BIT)
        : hitStatus ? 32'(flags_reg)
        : hitMasks ? 32'(masks_reg)
        : hitEvt ? 32'(evt_reg)
        : hitEvtMask ? 32'(evtMask_reg)
        : hitInfo ? (32'(faultVector_reg) << fpuexc_pkg::INFO_VEC_LSB) | 32'(imageBytes_reg)
        : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Error pin synchroniser and pending detection
    logic pendingInt;
    logic extError;
    logic pendingLine;

    // Two flops before the pin is used
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            pinSync_reg <= 2'h3;
        else
            pinSync_reg <= {pinSync_reg[0], coprocErrorN};
    end

    assign pendingInt = |(flags_reg & ~masks_reg);
    assign extError = !pinSync_reg[1];
    assign pendingLine = nativeErrorReportSelect_reg ? pendingInt : (pendingInt || extError);

    ////////////////////////////////////////////////////////////////////////
    // Issue decision
    logic [9:0] sizeNow;
    logic misalignNow;
    logic abridgedNow;
    logic faultNow;
    logic [7:0] vectorNow;
    logic notAvailNow;
    logic numNow;
    logic alignNow;
    logic goNow;
    logic legacySaveGo;
    logic restoreGo;

    fpuexc_image_sizer u_sizer (
        .instrClass(instrClass),
        .opSize32(opSize32),
        .addrLow(imageAddrLow),
        .imageBytes(sizeNow),
        .misaligned(misalignNow),
        .tagAbridged(abridgedNow)
    );

    fpuexc_fault_arb u_arb (
        .tsFlag(taskSwitchedFlag_reg),
        .isFp(fpuexc_pkg::fpuexc_is_fp(instrClass)),
        .misaligned(misalignNow),
        .waits(fpuexc_pkg::fpuexc_waits(instrClass)),
        .pending(pendingLine),
        .alignVector(ALIGN_VECTOR),
        .fault(faultNow),
        .vector(vectorNow),
        .notAvailTaken(notAvailNow),
        .numTaken(numNow),
        .alignTaken(alignNow)
    );

    assign goNow = instrValid && !faultNow;
    assign legacySaveGo = goNow && ((instrClass == fpuexc_pkg::IC_LEGACY_SAVE_NOWAIT)
        || (instrClass == fpuexc_pkg::IC_LEGACY_SAVE_WAIT));
    assign restoreGo = goNow && ((instrClass == fpuexc_pkg::IC_LEGACY_RESTORE)
        || (instrClass == fpuexc_pkg::IC_EXTENDED_RESTORE));

    ////////////////////////////////////////////////////////////////////////
    // Status word and control word next values
    always_comb
    begin
        flags_next = flags_reg;
        masks_next = masks_reg;
        if (wrEn && hitStatus)
            flags_next = pwdata[FW-1:0];
        if (wrEn && hitMasks)
            masks_next = pwdata[FW-1:0];
        if (legacySaveGo)
        begin
            flags_next = fpuexc_pkg::FLAGS_RESET;
            masks_next = fpuexc_pkg::MASK_RESET;
        end
        if (restoreGo)
            flags_next = restoreFlags;
        // New exceptions win over any clear
        if (excValid)
            flags_next = flags_next | excFlags;
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt events, write one to clear, set wins
    logic [EW-1:0] evtSet;
    logic [EW-1:0] evtClr;

    assign evtSet = {excValid && |(excFlags & ~masks_reg),
        instrValid && alignNow, instrValid && numNow, instrValid && notAvailNow};
    assign evtClr = (wrEn && hitEvt) ? pwdata[EW-1:0] : '0;

    ////////////////////////////////////////////////////////////////////////
    // Register updates
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            taskSwitchedFlag_reg <= 1'b0;
            nativeErrorReportSelect_reg <= 1'b0;
            flags_reg <= fpuexc_pkg::FLAGS_RESET;
            masks_reg <= fpuexc_pkg::MASK_RESET;
            evt_reg <= '0;
            evtMask_reg <= '0;
        end
        else
        begin
            if (wrEn && hitCtrl)
            begin
                taskSwitchedFlag_reg <= pwdata[fpuexc_pkg::TASK_SWITCHED_BIT];
                nativeErrorReportSelect_reg <= pwdata[fpuexc_pkg::NATIVE_SEL_BIT];
            end
            if (wrEn && hitEvtMask)
                evtMask_reg <= pwdata[EW-1:0];
            flags_reg <= flags_next;
            masks_reg <= masks_next;
            evt_reg <= (evt_reg & ~evtClr) | evtSet;
        end
    end

    // APB answer, one wait state
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
        else
        begin
            pready_reg <= apbAccess;
            pslverr_reg <= apbAccess && !hitAny;
            prdata_reg <= (apbAccess && !pwrite) ? readMux : 32'h0000_0000;
        end
    end

    // Issue results and error lines
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            instrGo_reg <= 1'b0;
            instrFault_reg <= 1'b0;
            faultVector_reg <= 8'h00;
            imageBytes_reg <= '0;
            tagAbridged_reg <= 1'b0;
            unitReinit_reg <= 1'b0;
            fpuErrorOutputN_reg <= 1'b1;
            errorStatusN_reg <= 1'b1;
            irq_reg <= 1'b0;
        end
        else
        begin
            instrGo_reg <= goNow;
            instrFault_reg <= instrValid && faultNow;
            if (instrValid && faultNow)
                faultVector_reg <= vectorNow;
            if (goNow)
            begin
                imageBytes_reg <= sizeNow;
                tagAbridged_reg <= abridgedNow;
            end
            unitReinit_reg <= legacySaveGo;
            fpuErrorOutputN_reg <= !pendingInt;
            errorStatusN_reg <= !pendingInt;
            irq_reg <= |(evt_reg & evtMask_reg);
        end
    end

    // Ports straight from flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign instrGo = instrGo_reg;
    assign instrFault = instrFault_reg;
    assign faultVector = faultVector_reg;
    assign imageBytes = imageBytes_reg;
    assign tagAbridged = tagAbridged_reg;
    assign unitReinit = unitReinit_reg;
    assign fpuErrorOutputN = fpuErrorOutputN_reg;
    assign errorStatusN = errorStatusN_reg;
    assign irq = irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // device fault first
    AST_NOT_AVAIL_FIRST: assert property (@(posedge clk) disable iff (reset)
        instrValid && taskSwitchedFlag_reg && pendingLine && instrClass != fpuexc_pkg::IC_WAIT
        |=> instrFault && faultVector == fpuexc_pkg::VEC_NOT_AVAIL && !instrGo)
        else $error("device fault lost priority");

    AST_NOWAIT_SAVE_ERR: assert property (@(posedge clk) disable iff (reset)
        instrValid && instrClass == fpuexc_pkg::IC_LEGACY_SAVE_NOWAIT
        && pendingInt && !taskSwitchedFlag_reg && !excValid
        |=> !fpuErrorOutputN && unitReinit ##1 fpuErrorOutputN)
        else $error("no-wait save did not pulse error output");

    AST_RESTORE_RELOAD: assert property (@(posedge clk) disable iff (reset)
        restoreGo && !excValid |=> flags_reg == $past(restoreFlags))
        else $error("restore did not reload flags");

    AST_LEGACY_SIZE: assert property (@(posedge clk) disable iff (reset)
        goNow && instrClass == fpuexc_pkg::IC_LEGACY_RESTORE
        |=> imageBytes == (($past(opSize32)) ? fpuexc_pkg::BYTES_LEGACY32
        : fpuexc_pkg::BYTES_LEGACY16))
        else $error("legacy image length wrong");

    AST_EXT_SIZE: assert property (@(posedge clk) disable iff (reset)
        goNow && instrClass == fpuexc_pkg::IC_EXTENDED_SAVE
        |=> imageBytes == fpuexc_pkg::BYTES_EXTENDED && tagAbridged)
        else $error("extended image length wrong");

    AST_ALIGN_FAULT: assert property (@(posedge clk) disable iff (reset)
        instrValid && !taskSwitchedFlag_reg && (instrClass == fpuexc_pkg::IC_EXTENDED_SAVE
        || instrClass == fpuexc_pkg::IC_EXTENDED_RESTORE)
        && imageAddrLow != 4'h0 |=> instrFault && faultVector == ALIGN_VECTOR)
        else $error("misaligned image not faulted");

    AST_EXT_KEEPS: assert property (@(posedge clk) disable iff (reset)
        goNow && instrClass == fpuexc_pkg::IC_EXTENDED_SAVE && !excValid && !wrEn
        |=> $stable(flags_reg) && $stable(masks_reg) && !unitReinit)
        else $error("extended save changed unit state");

    AST_ERR_STATUS: assert property (@(posedge clk) disable iff (reset)
        excValid && |(excFlags & ~masks_reg) && !legacySaveGo && !(wrEn && (hitStatus || hitMasks))
        |-> ##2 !errorStatusN)
        else $error("error status not asserted");

    AST_NOWAIT_RUNS: assert property (@(posedge clk) disable iff (reset)
        instrValid && instrClass == fpuexc_pkg::IC_NOWAIT && !taskSwitchedFlag_reg
        |=> instrGo && !instrFault)
        else $error("no-wait instruction trapped");

    AST_NATIVE_VEC: assert property (@(posedge clk) disable iff (reset)
        instrValid && nativeErrorReportSelect_reg && pendingInt && !taskSwitchedFlag_reg
        && instrClass == fpuexc_pkg::IC_ARITH
        |=> instrFault && faultVector == fpuexc_pkg::VEC_NUMERIC)
        else $error("native numeric fault missing");
endmodule
